/* File: sim/safe_ctrl_model.sv */
`timescale 1ns/1ps
module safe_ctrl_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench requests
    input wire logic [3:0] want_cmd,
    input wire logic ack_req,
    // toward the terminal
    output logic [3:0] safe_cmd,
    output logic [3:0] std_cmd,
    output logic group_error_acknowledge
);
    logic [7:0] lfsr_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            safe_cmd <= 4'h0;
            std_cmd <= 4'h0;
            group_error_acknowledge <= 1'b0;
            lfsr_ff <= 8'hA5;
        end else begin
            safe_cmd <= want_cmd;
            // plc bits wander; with gating off they must not reach the outputs
            lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
            std_cmd <= lfsr_ff[3:0];
            group_error_acknowledge <= ack_req;
        end
    end
endmodule : safe_ctrl_model

/* File: sim/safe_out_asserts.sv */
`timescale 1ns/1ps
module safe_out_asserts
    import safe_out_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // field side
    input wire logic [3:0] safe_cmd,
    input wire fault_s fault_in,
    input wire logic internal_err,
    input wire logic [3:0] safe_out,
    input wire logic led_int_err
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence any_fault;
        (|fault_in) || internal_err;
    endsequence
    wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response not two cycles after request");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    rd_answer_a: assert property ($rose(s_axi_arvalid) && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read data not one cycle after request");
    out_gated_a: assert property ((safe_out & ~$past(safe_cmd)) == 4'h0)
        else $error("output on without safety command");
    fault_off_a: assert property (any_fault |-> ##3 (safe_out == 4'h0) [*8])
        else $error("output not held off after fault");
    int_led_a: assert property (internal_err |-> ##[1:3] led_int_err)
        else $error("internal error indicator not lit");
    int_latch_a: assert property (led_int_err |=> led_int_err)
        else $error("internal error indicator released");
    shut_down_a: assert property (led_int_err |=> safe_out == 4'h0)
        else $error("output on during shutdown");
endmodule : safe_out_asserts

bind safe_output_diag_control safe_out_asserts u_asserts (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .safe_cmd, .fault_in,
    .internal_err, .safe_out, .led_int_err);

/* File: sim/safe_output_diag_control_tb_top.sv */
`timescale 1ns/1ps
`include "safe_out_defs.svh"
module safe_output_diag_control_tb_top
    import safe_out_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd, v;
    logic [3:0] safe_cmd, std_cmd, safe_out, want_cmd = 4'h0;
    logic group_error_acknowledge, ack_req = 1'b0, internal_err = 1'b0, seen;
    fault_s fault_in = 10'h000;
    logic [3:0] internal_code [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
    logic [15:0] temp1_in = 16'h0, temp2_in = 16'h0, temp_out_in = 16'h0;
    logic conn_reset, led_out_fault, led_int_err, led_int_detail;
    int fails = 0, checks = 0, zeros, odd, c;

    always #50 aclk = ~aclk;

    // short tick keeps blink codes within a few hundred cycles
    safe_output_diag_control #(.TICK_COUNT(4)) dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .safe_cmd, .std_cmd, .group_error_acknowledge, .fault_in,
        .internal_err, .internal_code, .temp1_in, .temp2_in, .temp_out_in, .safe_out,
        .conn_reset, .led_out_fault, .led_int_err, .led_int_detail);
    safe_ctrl_model partner (.aclk, .aresetn, .want_cmd, .ack_req, .safe_cmd, .std_cmd,
        .group_error_acknowledge);

    task test_done;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task do_reset;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : do_reset

    // handshakes are judged mid-cycle, so the edge that takes them is never raced
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic da, dw, db;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        repeat (50) begin
            @(negedge aclk);
            da = s_axi_awvalid && s_axi_awready;
            dw = s_axi_wvalid && s_axi_wready;
            db = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (da) s_axi_awvalid <= 1'b0;
            if (dw) s_axi_wvalid <= 1'b0;
            if (db) begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        fails++;
        test_done;
    endtask : wr

    task rdt(input logic [11:0] a);
        logic dr, dd;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        repeat (50) begin
            @(negedge aclk);
            dr = s_axi_arvalid && s_axi_arready;
            dd = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (dr || dd) s_axi_arvalid <= 1'b0;
            if (dd) begin
                s_axi_rready <= 1'b0;
                return;
            end
        end
        fails++;
        test_done;
    endtask : rdt

    task rchk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        rdt(a);
        chk(what, e, rd & m);
    endtask : rchk

    task watch(input int n, input logic which);
        seen = 1'b0;
        repeat (n) begin
            @(negedge aclk);
            seen = seen | (which ? led_int_detail : led_out_fault);
        end
    endtask : watch

    function fault_s fault_vec(input int k);
        if (k <= 4) return fault_s'(10'h040 << (k - 1));
        return fault_s'(10'h001 << (10 - k));
    endfunction : fault_vec

    function logic [31:0] code_field(input int k);
        return 32'(k) << 4;
    endfunction : code_field

    initial begin
        void'($urandom(19304));
        do_reset;
        rchk("ctrl", `ADDR_CTRL, 32'hF, 32'h6);
        rchk("store", `ADDR_STORE_CODE, 32'hFFFFFFFF, 32'h0);
        rchk("crc", `ADDR_PROJECT_CRC, 32'hFFFFFFFF, 32'h0);
        rchk("temp1", `ADDR_TEMP1, 32'hFFFFFFFF, 32'h0);
        rchk("temp out", `ADDR_TEMP_OUT, 32'hFFFFFFFF, 32'h0);
        temp1_in <= 16'($urandom());
        temp2_in <= 16'($urandom());
        temp_out_in <= 16'hFFFF;
        wr(`ADDR_TEMP1, 32'h0000A5A5);
        rchk("temp1", `ADDR_TEMP1, 32'hFFFFFFFF, {16'h0, temp1_in});
        rchk("temp2", `ADDR_TEMP2, 32'hFFFFFFFF, {16'h0, temp2_in});
        rchk("temp out", `ADDR_TEMP_OUT, 32'hFFFFFFFF, {16'h0, temp_out_in});
        rdt(12'h020);
        chk("bad rd resp", 32'h2, {30'h0, rsp});
        chk("bad rd data", 32'h0, rd);
        wr(12'h024, 32'h1);
        chk("bad wr resp", 32'h2, {30'h0, rsp});
        v = $urandom();
        wr(`ADDR_STORE_CODE, v);
        rchk("store", `ADDR_STORE_CODE, 32'hFFFF, v & 32'hFFFF);
        wr(`ADDR_PROJECT_CRC, 32'h0000FFFF);
        rchk("crc", `ADDR_PROJECT_CRC, 32'hFFFF, 32'hFFFF);
        want_cmd <= 4'hF;
        repeat (20) @(posedge aclk);
        zeros = 0;
        odd = 0;
        repeat (10000) begin
            @(negedge aclk);
            if (safe_out === 4'h0) zeros++;
            else if (safe_out !== 4'hF) odd++;
        end
        chk("pulse cycles", 32'd10, 32'(zeros));
        chk("odd levels", 32'h0, 32'(odd));
        for (c = 1; c <= 10; c++) begin
            do_reset;
            fault_in <= fault_vec(c);
            repeat (5) @(posedge aclk);
            fault_in <= 10'h000;
            ack_req <= 1'b1;
            repeat (2) @(posedge aclk);
            ack_req <= 1'b0;
            watch(200, 1'b0);
            chk("fault led", 32'h1, {31'h0, seen});
            chk("latched out", 32'h0, {28'h0, safe_out});
            rchk("err code", `ADDR_STATUS, 32'hFC, code_field(c));
        end
        do_reset;
        foreach (internal_code[j]) internal_code[j] <= 4'($urandom_range(1, 15));
        internal_err <= 1'b1;
        repeat (3) @(posedge aclk);
        internal_err <= 1'b0;
        watch(300, 1'b1);
        chk("detail led", 32'h1, {31'h0, seen});
        chk("int led", 32'h1, {31'h0, led_int_err});
        rchk("shutdown", `ADDR_STATUS, 32'h8, 32'h8);
        do_reset;
        wr(`ADDR_CTRL, 32'h1);
        odd = 0;
        @(negedge aclk);
        v = {28'h0, safe_cmd & std_cmd};
        repeat (300) begin
            @(negedge aclk);
            if (safe_out !== v[3:0]) odd++;
            v = {28'h0, safe_cmd & std_cmd};
        end
        chk("gated out", 32'h0, 32'(odd));
        wr(`ADDR_CTRL, 32'h6);
        rchk("fail stop", `ADDR_STATUS, 32'h4, 32'h4);
        chk("stopped out", 32'h0, {28'h0, safe_out});
        wr(`ADDR_STORE_CODE, 32'h1234);
        rchk("dropped", `ADDR_STORE_CODE, 32'hFFFF, 32'h0);
        do_reset;
        wr(`ADDR_CTRL, 32'hE);
        fault_in <= fault_vec(3);
        repeat (3) @(posedge aclk);
        fault_in <= 10'h000;
        rchk("conn code", `ADDR_ERR_CODE, 32'hFF, 32'h0E);
        chk("conn reset", 32'h1, {31'h0, conn_reset});
        ack_req <= 1'b1;
        repeat (2) @(posedge aclk);
        ack_req <= 1'b0;
        rchk("conn code", `ADDR_ERR_CODE, 32'hFF, 32'h0);
        chk("conn reset", 32'h0, {31'h0, conn_reset});
        test_done;
    end
endmodule : safe_output_diag_control_tb_top

/* File: src/safe_out_defs.svh */
`ifndef SAFE_OUT_DEFS_SVH
`define SAFE_OUT_DEFS_SVH
`define ADDR_CTRL 12'h000
`define ADDR_STORE_CODE 12'h004
`define ADDR_PROJECT_CRC 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_TEMP1 12'h010
`define ADDR_TEMP2 12'h014
`define ADDR_TEMP_OUT 12'h018
`define ADDR_ERR_CODE 12'h01C
`define CTRL_STD_GATE 0
`define CTRL_CUR_MEAS 1
`define CTRL_OUT_TEST 2
`define CTRL_ERR_ACK 3
`define CTRL_RESET 4'h6
`define PARAM_RESET 16'h0000
`define CONN_ERR_CODE 8'h0E
`define TICK_NS 50000000
`define CLK_NS 100
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`define TEST_PULSE_CYCLES 8'h0A
`define TEST_PERIOD_CYCLES 16'h2710
`define FLICKER_TICKS 5'h08
`define SHORT_PAUSE_TICKS 5'h04
`define LONG_PAUSE_TICKS 5'h0C
`endif

/* File: src/safe_out_pkg.sv */
package safe_out_pkg;
    typedef enum logic [2:0] {
        blk_idle,
        blk_flicker,
        blk_on,
        blk_off,
        blk_pause
    } blink_state_e;
    typedef struct packed {
        logic std_gate;
        logic cur_meas;
        logic out_test;
        logic err_ack;
    } ctrl_s;
    typedef struct packed {
        logic [3:0] chan_err;
        logic volt_low;
        logic volt_high;
        logic temp_low;
        logic temp_high;
        logic temp_diff;
        logic circuit_err;
    } fault_s;
endpackage : safe_out_pkg

/* File: src/safe_output_diag_control.sv */
`timescale 1ns/1ps
`include "safe_out_defs.svh"
// Function
// - with standard gating on, each safe output is the safety command ANDed with the PLC bit.
// - test pulses are produced when current measurement or output testing is on, else none.
// - with acknowledge on, a terminal error resets the connection and shows code 14 until acknowledged.
// - with acknowledge off, a terminal error latches until power cycling and no command clears it.
// - store code and project checksum parameters are held, both resetting to 0x0000.
// - an error on channel N (1 to 4) blinks flicker then N pulses on the output-fault LED.
// - field voltage too low gives 5 pulses, too high gives 6.
// - temperature low 7, high 8, difference 9, output circuit error 10 pulses.
// - errors shown on the output-fault LED stay latched until power cycling.
// - an internal error lights the indicator, blinks the detail LED and shuts the device down.
// - the internal code is four counted sequences with short pauses, then a long pause, repeating.
// - any control write with byte 0 strobed after the first (start-up setup) write forces permanent fail-stop.
// - three read-only temperature readings are exposed, zero by default.
module safe_output_diag_control
    import safe_out_pkg::*;
#(
    parameter int TICK_COUNT = `TICK_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // safety and plc commands
    input wire logic [3:0] safe_cmd,
    input wire logic [3:0] std_cmd,
    input wire logic group_error_acknowledge,
    // field status
    input wire fault_s fault_in,
    input wire logic internal_err,
    input wire logic [3:0] internal_code [4],
    input wire logic [15:0] temp1_in,
    input wire logic [15:0] temp2_in,
    input wire logic [15:0] temp_out_in,
    // outputs and leds
    output logic [3:0] safe_out,
    output logic conn_reset,
    output logic led_out_fault,
    output logic led_int_err,
    output logic led_int_detail
);
    ctrl_s ctrl_ff;
    logic [15:0] store_code_ff, project_crc_ff;
    logic [15:0] temp1_ff, temp2_ff, temp_out_ff;
    logic [3:0] err_code_ff;
    logic conn_err_ff, fail_stop_ff, shutdown_ff, cfg_done_ff;
    logic aw_hold_ff, w_hold_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [31:0] tick_cnt_ff;
    logic tick_ff;
    logic [15:0] test_cnt_ff;
    logic pulse_ff;
    logic do_write;
    logic [3:0] nxt_code;
    logic [3:0] code_ff;
    blink_state_e fst_ff, ist_ff;
    logic [4:0] fdly_ff, idly_ff;
    logic [3:0] fcnt_ff, icnt_ff;
    logic [1:0] iseq_ff;

    assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;

    // write channel capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            // ready flops see the next hold and response state
            s_axi_awready <= !aw_hold_ff && !(s_axi_awvalid && s_axi_awready) &&
                             !(s_axi_bvalid && !s_axi_bready);
            s_axi_wready <= !w_hold_ff && !(s_axi_wvalid && s_axi_wready) &&
                            !(s_axi_bvalid && !s_axi_bready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_ff == `ADDR_CTRL || awaddr_ff == `ADDR_STORE_CODE ||
                    awaddr_ff == `ADDR_PROJECT_CRC) begin
                    s_axi_bresp <= 2'h0;
                end else begin
                    s_axi_bresp <= 2'h2;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // first ctrl write is start-up setup, a later one a forbidden change; fail-stop drops all
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= `CTRL_RESET;
            store_code_ff <= `PARAM_RESET;
            project_crc_ff <= `PARAM_RESET;
            fail_stop_ff <= 1'b0;
            cfg_done_ff <= 1'b0;
        end else if (do_write && !fail_stop_ff) begin
            if (awaddr_ff == `ADDR_CTRL) begin
                if (wstrb_ff[0] && cfg_done_ff) begin
                    fail_stop_ff <= 1'b1;
                end else if (wstrb_ff[0]) begin
                    ctrl_ff <= {wdata_ff[`CTRL_STD_GATE], wdata_ff[`CTRL_CUR_MEAS],
                                wdata_ff[`CTRL_OUT_TEST], wdata_ff[`CTRL_ERR_ACK]};
                    cfg_done_ff <= 1'b1;
                end
            end else if (awaddr_ff == `ADDR_STORE_CODE) begin
                if (wstrb_ff[0]) store_code_ff[7:0] <= wdata_ff[7:0];
                if (wstrb_ff[1]) store_code_ff[15:8] <= wdata_ff[15:8];
            end else if (awaddr_ff == `ADDR_PROJECT_CRC) begin
                if (wstrb_ff[0]) project_crc_ff[7:0] <= wdata_ff[7:0];
                if (wstrb_ff[1]) project_crc_ff[15:8] <= wdata_ff[15:8];
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                if (s_axi_araddr == `ADDR_CTRL) begin
                    s_axi_rdata <= {28'h0, ctrl_ff.err_ack, ctrl_ff.out_test,
                                    ctrl_ff.cur_meas, ctrl_ff.std_gate};
                end else if (s_axi_araddr == `ADDR_STORE_CODE) begin
                    s_axi_rdata <= {16'h0, store_code_ff};
                end else if (s_axi_araddr == `ADDR_PROJECT_CRC) begin
                    s_axi_rdata <= {16'h0, project_crc_ff};
                end else if (s_axi_araddr == `ADDR_STATUS) begin
                    s_axi_rdata <= {24'h0, err_code_ff, shutdown_ff, fail_stop_ff,
                                    conn_err_ff, led_out_fault};
                end else if (s_axi_araddr == `ADDR_TEMP1) begin
                    s_axi_rdata <= {16'h0, temp1_ff};
                end else if (s_axi_araddr == `ADDR_TEMP2) begin
                    s_axi_rdata <= {16'h0, temp2_ff};
                end else if (s_axi_araddr == `ADDR_TEMP_OUT) begin
                    s_axi_rdata <= {16'h0, temp_out_ff};
                end else if (s_axi_araddr == `ADDR_ERR_CODE) begin
                    s_axi_rdata <= {24'h0, conn_err_ff ? `CONN_ERR_CODE : 8'h00};
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            end
        end
    end

    // temperature sampling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            temp1_ff <= 16'h0000;
            temp2_ff <= 16'h0000;
            temp_out_ff <= 16'h0000;
        end else begin
            temp1_ff <= temp1_in;
            temp2_ff <= temp2_in;
            temp_out_ff <= temp_out_in;
        end
    end

    // highest priority fault picks the pulse count
    always_comb begin
        nxt_code = 4'h0;
        if (fault_in.chan_err[0]) nxt_code = 4'h1;
        else if (fault_in.chan_err[1]) nxt_code = 4'h2;
        else if (fault_in.chan_err[2]) nxt_code = 4'h3;
        else if (fault_in.chan_err[3]) nxt_code = 4'h4;
        else if (fault_in.volt_low) nxt_code = 4'h5;
        else if (fault_in.volt_high) nxt_code = 4'h6;
        else if (fault_in.temp_low) nxt_code = 4'h7;
        else if (fault_in.temp_high) nxt_code = 4'h8;
        else if (fault_in.temp_diff) nxt_code = 4'h9;
        else if (fault_in.circuit_err) nxt_code = 4'hA;
    end

    // latched terminal error; only a power-up reset clears the code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_code_ff <= 4'h0;
        end else if (err_code_ff == 4'h0 && nxt_code != 4'h0) begin
            err_code_ff <= nxt_code;
        end
    end

    // connection reset with code 14 when acknowledge mode is on; new error beats ack
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conn_err_ff <= 1'b0;
        end else if (ctrl_ff.err_ack && nxt_code != 4'h0) begin
            conn_err_ff <= 1'b1;
        end else if (group_error_acknowledge) begin
            conn_err_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shutdown_ff <= 1'b0;
        end else if (internal_err) begin
            shutdown_ff <= 1'b1;
        end
    end

    // free running blink tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_ff <= 32'h00000000;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff >= 32'(TICK_COUNT - 1)) begin
            tick_cnt_ff <= 32'h00000000;
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
            tick_ff <= 1'b0;
        end
    end

    // short low test pulse once per period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_cnt_ff <= 16'h0000;
            pulse_ff <= 1'b0;
        end else begin
            test_cnt_ff <= (test_cnt_ff >= `TEST_PERIOD_CYCLES - 16'h0001) ? 16'h0000 :
                           test_cnt_ff + 16'h0001;
            pulse_ff <= (ctrl_ff.cur_meas || ctrl_ff.out_test) &&
                        (test_cnt_ff < {8'h00, `TEST_PULSE_CYCLES});
        end
    end

    // output drive; any error, fail-stop or shutdown forces safe state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            safe_out <= 4'h0;
            conn_reset <= 1'b0;
            led_int_err <= 1'b0;
        end else begin
            conn_reset <= conn_err_ff;
            led_int_err <= shutdown_ff;
            if (fail_stop_ff || shutdown_ff || err_code_ff != 4'h0 || conn_err_ff) begin
                safe_out <= 4'h0;
            end else if (ctrl_ff.std_gate) begin
                safe_out <= (safe_cmd & std_cmd) & {4{!pulse_ff}};
            end else begin
                safe_out <= safe_cmd & {4{!pulse_ff}};
            end
        end
    end

    // output-fault blinker: flicker, then code pulses, then repeat
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fst_ff <= blk_idle;
            fdly_ff <= 5'h00;
            fcnt_ff <= 4'h0;
            led_out_fault <= 1'b0;
        end else if (tick_ff) begin
            case (fst_ff)
                blk_idle: begin
                    led_out_fault <= 1'b0;
                    if (err_code_ff != 4'h0) begin
                        fst_ff <= blk_flicker;
                        fdly_ff <= `FLICKER_TICKS;
                    end
                end
                blk_flicker: begin
                    led_out_fault <= !led_out_fault;
                    fdly_ff <= fdly_ff - 5'h01;
                    if (fdly_ff == 5'h01) begin
                        fst_ff <= blk_pause;
                        fcnt_ff <= err_code_ff;
                    end
                end
                blk_pause: begin
                    led_out_fault <= 1'b0;
                    fst_ff <= blk_on;
                end
                blk_on: begin
                    led_out_fault <= 1'b1;
                    fcnt_ff <= fcnt_ff - 4'h1;
                    fst_ff <= blk_off;
                end
                default: begin
                    led_out_fault <= 1'b0;
                    if (fcnt_ff == 4'h0) begin
                        fst_ff <= blk_flicker;
                        fdly_ff <= `FLICKER_TICKS;
                    end else begin
                        fst_ff <= blk_on;
                    end
                end
            endcase
        end
    end

    // track code while idle so the first sequence is ready; reloaded with the next code at the end of each pause
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_ff <= 4'h0;
        end else if (ist_ff == blk_idle) begin
            code_ff <= internal_code[0];
        end else if (ist_ff == blk_pause && idly_ff == 5'h01 && tick_ff) begin
            code_ff <= internal_code[iseq_ff];
        end
    end

    // detail blinker: four counted sequences, short pauses, long pause
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ist_ff <= blk_idle;
            idly_ff <= 5'h00;
            icnt_ff <= 4'h0;
            iseq_ff <= 2'h0;
            led_int_detail <= 1'b0;
        end else if (tick_ff) begin
            case (ist_ff)
                blk_idle: begin
                    led_int_detail <= 1'b0;
                    if (shutdown_ff) begin
                        ist_ff <= blk_on;
                        icnt_ff <= code_ff;
                        iseq_ff <= 2'h0;
                    end
                end
                blk_on: begin
                    led_int_detail <= icnt_ff != 4'h0;
                    icnt_ff <= (icnt_ff == 4'h0) ? 4'h0 : icnt_ff - 4'h1;
                    ist_ff <= blk_off;
                end
                blk_off: begin
                    led_int_detail <= 1'b0;
                    if (icnt_ff != 4'h0) begin
                        ist_ff <= blk_on;
                    end else begin
                        ist_ff <= blk_pause;
                        iseq_ff <= iseq_ff + 2'h1;
                        idly_ff <= (iseq_ff == 2'h3) ? `LONG_PAUSE_TICKS :
                                   `SHORT_PAUSE_TICKS;
                    end
                end
                default: begin
                    led_int_detail <= 1'b0;
                    idly_ff <= idly_ff - 5'h01;
                    if (idly_ff == 5'h01) begin
                        ist_ff <= blk_flicker;
                    end
                end
            endcase
            if (ist_ff == blk_flicker) begin
                ist_ff <= blk_on;
                icnt_ff <= code_ff;
            end
        end
    end
endmodule : safe_output_diag_control
